/* core/glclk_cfg.svh */
`ifndef GLCLK_CFG_SVH
`define GLCLK_CFG_SVH

// Number of gated global clock networks
`define GLCLK_NUM_NET   4
// Number of selectable clock sources per network
`define GLCLK_NUM_SRC   4
// Width of a source-select code
`define GLCLK_SEL_W     2
// Source select held while not in user mode
`define GLCLK_SEL_RST   2'h0
// Reset value of every enable register
`define GLCLK_EN_RST    1'h0
// Reset value of the configuration-done synchroniser bits
`define GLCLK_CFG_RST   1'h0

`endif

/* core/glclk_pkg.sv */
package glclk_pkg;

  // Dynamic source-select code of one network
  typedef logic [1:0] glclk_sel_t;

  // Device phase: loading configuration, or running user logic
  typedef enum logic [1:0] {
    GLCLK_CONFIG,
    GLCLK_LOAD,
    GLCLK_USER
  } glclk_mode_t;

endpackage : glclk_pkg

/* core/glclk_gate_cell.sv */
`timescale 1ns/1ns
`include "glclk_cfg.svh"

// Enable path and gate for one global clock network
module glclk_gate_cell (
  input  wire logic clk,          // Source clock of the network
  input  wire logic rst_n,        // Synchronised reset, active low
  input  wire logic load_init,    // One-cycle pulse at configuration completion
  input  wire logic user_mode,    // High once user mode is entered
  input  wire logic net_used,     // Static bit: network in use
  input  wire logic init_en,      // Static bit: enabled state at configuration completion
  input  wire logic two_stage,    // Static bit: network carries pll_counter_out_zero to a pin
  input  wire logic ena_in,       // Dynamic enable from user logic
  input  wire logic src_tick,     // Selected source, one-cycle tick
  output logic      tick_q,       // Gated network tick
  output logic      on_q          // Network currently enabled
);

  logic stage1_q;                 // First enable register
  logic stage2_q;                 // Second enable register, cascaded path only
  logic en_eff;                   // Enable seen by the gate

  // First enable register, captured on the falling edge of the source clock
  always_ff @(negedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_q <= `GLCLK_EN_RST;
    end
    else if (load_init)
    begin
      // Defined state at configuration completion; unused networks stay off
      stage1_q <= init_en & net_used; // RULE15 RULE1
    end
    else if (user_mode)
    begin
      // Dynamic enable, masked by the static disable
      stage1_q <= ena_in & net_used; // RULE9 RULE2 RULE1
    end
  end

  // Second register of the cascaded path, also on the falling edge
  always_ff @(negedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage2_q <= `GLCLK_EN_RST;
    end
    else if (load_init)
    begin
      stage2_q <= init_en & net_used; // RULE15
    end
    else
    begin
      stage2_q <= stage1_q & net_used; // RULE8
    end
  end

  // Pick one register or two in cascade
  assign en_eff = two_stage ? stage2_q : stage1_q; // RULE7 RULE8

  // Gate: source AND enable; enable only moved while the source was low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_q <= 1'b0;
      on_q   <= 1'b0;
    end
    else
    begin
      // No tick leaves a disabled network; resumes at once when re-enabled
      tick_q <= src_tick & en_eff; // RULE14 RULE3 RULE5
      on_q   <= en_eff;
    end
  end

endmodule : glclk_gate_cell

/* core/glclk_top.sv */
`timescale 1ns/1ns
`include "glclk_cfg.svh"

// Operation
// RULE1: Static bit disables network; unused held off
// RULE2: Dynamic user enable switches network in user mode
// RULE3: Disabled network delivers no clock edges
// RULE4: Gate after source select, independent of PLL
// RULE5: Re-enable resumes at once, no relock
// RULE6: PLL lock and counters unaffected by enable
// RULE7: Network enable path uses one register
// RULE8: Counter-zero pin path uses two registers
// RULE9: Enable captured on source clock falling edge
// RULE10: User may hold enable off during resync
// RULE11: User disables, then switches select lines
// RULE12: User waits some cycles before re-enabling
// RULE13: Two-bit select from user logic, user mode
// RULE14: Gated clock is source AND enable register
// RULE15: Enable registers initialised at configuration completion

// Clock control for a set of global clock networks
module glclk_top
  import glclk_pkg::*;
#(
  parameter int NUM_NET = `GLCLK_NUM_NET, // Networks served
  parameter int NUM_SRC = `GLCLK_NUM_SRC  // Sources per network
) (
  input  wire logic                 ref_clk,        // 20 MHz reference clock
  input  wire logic                 reset_n,        // Asynchronous reset, active low
  input  wire logic                 cfg_done,       // Configuration complete, pin level
  input  wire logic [NUM_NET-1:0]   cfg_net_used,   // Static: network in use
  input  wire logic [NUM_NET-1:0]   cfg_init_en,    // Static: enabled at completion
  input  wire logic [NUM_NET-1:0]   cfg_two_stage,  // Static: pll_counter_out_zero to pin
  input  wire logic [NUM_SRC-1:0]   src_tick,       // Source ticks from outside, pins
  input  wire logic [NUM_NET-1:0]   net_ena,        // Dynamic enables from user logic
  input  glclk_pkg::glclk_sel_t     net_sel [NUM_NET], // Dynamic source selects
  output logic [NUM_NET-1:0]        global_clock_network_q, // Gated network ticks
  output logic [NUM_NET-1:0]        net_on_q,       // Network enable state
  output logic                      user_mode_q     // User mode reached
);

  import glclk_pkg::*;

  // Refuse shapes that the select code cannot address, at elaboration
  if (NUM_NET < 1 || NUM_SRC < 1 || NUM_SRC > (1 << `GLCLK_SEL_W))
  begin : g_bad_shape
    $error("glclk_top: unsupported NUM_NET or NUM_SRC");
  end

  logic                 rst_s1_q;        // Reset release, first stage
  logic                 rst_s2_q;        // Reset release, second stage
  logic                 rst_n_int;       // Synchronised reset used inside
  logic                 done_s1_q;       // Configuration done, first stage
  logic                 done_s2_q;       // Configuration done, second stage
  logic [NUM_NET-1:0]   used_s1_q;       // Static bits, first stage
  logic [NUM_NET-1:0]   used_s2_q;       // Static bits, second stage
  logic [NUM_NET-1:0]   init_s1_q;       // Init state, first stage
  logic [NUM_NET-1:0]   init_s2_q;       // Init state, second stage
  logic [NUM_NET-1:0]   two_s1_q;        // Cascade choice, first stage
  logic [NUM_NET-1:0]   two_s2_q;        // Cascade choice, second stage
  logic [NUM_SRC-1:0]   src_s1_q;        // Source ticks, first stage
  logic [NUM_SRC-1:0]   src_s2_q;        // Source ticks, second stage
  logic [NUM_NET-1:0]   used_q;          // Captured static disable bits
  logic [NUM_NET-1:0]   init_q;          // Captured init states
  logic [NUM_NET-1:0]   two_q;           // Captured cascade choices
  glclk_mode_t          mode_q;          // Device phase
  logic                 load_init;       // Configuration load pulse
  logic                 user_mode;       // User mode level
  logic [NUM_NET-1:0]   net_tick;        // Gate cell ticks
  logic [NUM_NET-1:0]   net_on;          // Gate cell states

  // Reset release through two flip-flops
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  assign rst_n_int = rst_s2_q;

  // Two-flop synchronisers for every pin level
  always_ff @(posedge ref_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      done_s1_q <= `GLCLK_CFG_RST;
      done_s2_q <= `GLCLK_CFG_RST;
      used_s1_q <= '0;
      used_s2_q <= '0;
      init_s1_q <= '0;
      init_s2_q <= '0;
      two_s1_q  <= '0;
      two_s2_q  <= '0;
      src_s1_q  <= '0;
      src_s2_q  <= '0;
    end
    else
    begin
      done_s1_q <= cfg_done;
      done_s2_q <= done_s1_q;
      used_s1_q <= cfg_net_used;
      used_s2_q <= used_s1_q;
      init_s1_q <= cfg_init_en;
      init_s2_q <= init_s1_q;
      two_s1_q  <= cfg_two_stage;
      two_s2_q  <= two_s1_q;
      src_s1_q  <= src_tick;
      src_s2_q  <= src_s1_q;
    end
  end

  // Phase sequence: wait for configuration, load once, then run
  always_ff @(posedge ref_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      mode_q <= GLCLK_CONFIG;
    end
    else
    begin
      case (mode_q)
        GLCLK_CONFIG:
        begin
          // Configuration still loading
          if (done_s2_q)
          begin
            mode_q <= GLCLK_LOAD;
          end
        end
        GLCLK_LOAD:
        begin
          // Static bits taken this cycle
          mode_q <= GLCLK_USER;
        end
        GLCLK_USER:
        begin
          // Losing configuration returns to the loading phase
          if (!done_s2_q)
          begin
            mode_q <= GLCLK_CONFIG;
          end
        end
        default:
        begin
          mode_q <= GLCLK_CONFIG;
        end
      endcase
    end
  end

  assign load_init = (mode_q == GLCLK_LOAD);
  assign user_mode = (mode_q == GLCLK_USER);

  // Static configuration held for the whole of user mode
  always_ff @(posedge ref_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      used_q <= '0;
      init_q <= '0;
      two_q  <= '0;
    end
    else if (load_init)
    begin
      used_q <= used_s2_q; // RULE1
      init_q <= init_s2_q; // RULE15
      two_q  <= two_s2_q;  // RULE8
    end
  end

  // One gate per network; selection first, gate after it
  generate
    for (genvar n = 0; n < NUM_NET; n++)
    begin : g_net
      glclk_sel_t sel_eff;  // Select in force
      logic       src_sel;  // Selected source tick

      // User select counts only in user mode
      assign sel_eff = user_mode ? net_sel[n] : `GLCLK_SEL_RST; // RULE13

      // Gate sits after the multiplexer and never feeds back to a source
      assign src_sel = (int'(sel_eff) < NUM_SRC) ? src_s2_q[sel_eff] : 1'b0; // RULE4 RULE6

      glclk_gate_cell u_cell (
        .clk       (ref_clk),
        .rst_n     (rst_n_int),
        .load_init (load_init),
        .user_mode (user_mode),
        .net_used  (load_init ? used_s2_q[n] : used_q[n]),
        .init_en   (init_s2_q[n]),
        .two_stage (load_init ? two_s2_q[n] : two_q[n]),
        .ena_in    (net_ena[n]),
        .src_tick  (src_sel),
        .tick_q    (net_tick[n]),
        .on_q      (net_on[n])
      );
    end
  endgenerate

  // Registered outputs
  always_ff @(posedge ref_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      global_clock_network_q <= '0;
      net_on_q               <= '0;
      user_mode_q            <= 1'b0;
    end
    else
    begin
      global_clock_network_q <= net_tick; // RULE3
      net_on_q               <= net_on;
      user_mode_q            <= user_mode;
    end
  end

endmodule : glclk_top

/* dv/glclk_user_model.sv */
`timescale 1ns/1ns
// User logic driving network enables and source selects
module glclk_user_model
  import glclk_pkg::*;
#(
  parameter int NUM_NET  = 4,
  parameter int WAIT_CYC = 5 // Cycles on the new source before re-enable
) (
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  input  wire logic               user_mode,
  input  wire logic [NUM_NET-1:0] want_en,
  input  glclk_pkg::glclk_sel_t   want_sel [NUM_NET],
  output logic      [NUM_NET-1:0] net_ena,
  output glclk_pkg::glclk_sel_t   net_sel [NUM_NET]
);
  int hold [NUM_NET]; // Cycles left before enable may follow
  // Switchover sequence, one per network
  always_ff @(posedge ref_clk)
  begin
    for (int k = 0; k < NUM_NET; k++)
    begin
      if (!reset_n)
      begin
        net_ena[k] <= 1'b0;
        net_sel[k] <= 2'h0;
        hold[k] <= 0;
      end
      else if (user_mode && want_sel[k] !== net_sel[k])
      begin
        net_ena[k] <= 1'b0;
        if (!net_ena[k])
        begin
          net_sel[k] <= want_sel[k];
          hold[k] <= WAIT_CYC;
        end
      end
      else if (hold[k] > 0)
        hold[k] <= hold[k] - 1;
      else
        net_ena[k] <= want_en[k];
    end
  end
endmodule : glclk_user_model

/* dv/glclk_top_props.sv */
`timescale 1ns/1ns
// Port-level checks of the clock gate
module glclk_top_props
  import glclk_pkg::*;
#(
  parameter int NUM_NET = 4,
  parameter int NUM_SRC = 4
) (
  input wire logic               ref_clk,
  input wire logic               reset_n,
  input wire logic               cfg_done,
  input wire logic [NUM_NET-1:0] cfg_net_used,
  input wire logic [NUM_NET-1:0] cfg_init_en,
  input wire logic [NUM_NET-1:0] cfg_two_stage,
  input wire logic [NUM_SRC-1:0] src_tick,
  input wire logic [NUM_NET-1:0] net_ena,
  input glclk_pkg::glclk_sel_t   net_sel [NUM_NET],
  input wire logic [NUM_NET-1:0] global_clock_network_q,
  input wire logic [NUM_NET-1:0] net_on_q,
  input wire logic               user_mode_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Configuration held long enough to reach user mode
  sequence s_cfg_up;
    $rose(cfg_done) ##1 cfg_done [*6];
  endsequence
  sequence s_ena_rise(k);
    user_mode_q && cfg_net_used[k] && !net_on_q[k] && $rose(net_ena[k]);
  endsequence
  property p_mode_up;
    s_cfg_up |-> user_mode_q;
  endproperty
  property p_init_state;
    $rose(user_mode_q) |-> ##[0:1] (net_on_q == (cfg_init_en & cfg_net_used));
  endproperty
  property p_unused_off;
    user_mode_q |-> ((net_on_q | global_clock_network_q) & ~cfg_net_used) == '0;
  endproperty
  property p_tick_cause;
    global_clock_network_q != '0
      |-> ($past(src_tick, 3) | $past(src_tick, 4) | $past(src_tick, 5)) != '0;
  endproperty
  property p_on_late(int k);
    s_ena_rise(k) ##0 cfg_two_stage[k] |-> !net_on_q[k] [*3];
  endproperty
  property p_on_soon(int k);
    s_ena_rise(k) ##1 net_ena[k] [*5] |-> net_on_q[k];
  endproperty
  property p_off_soon(int k);
    user_mode_q && $fell(net_ena[k]) ##1 !net_ena[k] [*5] |-> !net_on_q[k];
  endproperty
  property p_no_tick_off(int k);
    !net_on_q[k] [*3] |-> !global_clock_network_q[k];
  endproperty
  a_mode_up : assert property (p_mode_up) else $error("user mode late");
  a_init_state : assert property (p_init_state) else $error("bad init state");
  a_unused_off : assert property (p_unused_off) else $error("unused net live");
  a_tick_cause : assert property (p_tick_cause) else $error("tick from nowhere");
  // Per-network enable path checks
  for (genvar k = 0; k < NUM_NET; k++)
  begin : g_net
    a_on_late : assert property (p_on_late(k)) else $error("two-stage early");
    a_on_soon : assert property (p_on_soon(k)) else $error("enable lost");
    a_off_soon : assert property (p_off_soon(k)) else $error("disable lost");
    a_no_tick_off : assert property (p_no_tick_off(k)) else $error("tick while off");
  end
endmodule : glclk_top_props

bind glclk_top glclk_top_props #(.NUM_NET(NUM_NET), .NUM_SRC(NUM_SRC)) i_props (
  .ref_clk, .reset_n, .cfg_done, .cfg_net_used, .cfg_init_en, .cfg_two_stage,
  .src_tick, .net_ena, .net_sel, .global_clock_network_q, .net_on_q, .user_mode_q);

/* dv/glclk_top_tb_top.sv */
`timescale 1ns/1ns
// Self-checking bench of the clock gate
module glclk_top_tb_top;
  import glclk_pkg::*;
  logic       ref_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       cfg_done = 1'b0;
  logic [3:0] cfg_net_used = 4'h0;
  logic [3:0] cfg_init_en = 4'h0;
  logic [3:0] cfg_two_stage = 4'h0;
  logic [3:0] src_tick = 4'h0;
  logic [3:0] want_en = 4'h0;
  logic [3:0] net_ena;
  logic [3:0] global_clock_network_q;
  logic [3:0] net_on_q;
  logic       user_mode_q;
  glclk_sel_t want_sel [4] = '{default: 2'h0};
  glclk_sel_t net_sel [4];
  int         fails = 0;
  int         tests_run = 0;
  int         cyc = 0;
  glclk_top i_dut (.ref_clk, .reset_n, .cfg_done, .cfg_net_used, .cfg_init_en,
    .cfg_two_stage, .src_tick, .net_ena, .net_sel, .global_clock_network_q,
    .net_on_q, .user_mode_q);
  glclk_user_model i_user (.ref_clk, .reset_n, .user_mode(user_mode_q), .want_en,
    .want_sel, .net_ena, .net_sel);
  always #25 ref_clk = ~ref_clk;
  // Source 0 ticks every 4 cycles, source 1 every 2; timeout guard
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    src_tick <= #2 {2'b00, cyc % 2 == 0, cyc % 4 == 0};
    if (cyc == 3000)
    begin
      fails++;
      close_out();
    end
  end
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic step(int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : step
  // Ticks of one network over 40 cycles
  task automatic ticks(int k, string what, int exp);
    int n;
    n = 0;
    repeat (40)
    begin
      step(1);
      n += (global_clock_network_q[k] === 1'b1);
    end
    check(what, 8'(exp), 8'(n));
  endtask : ticks
  task automatic t_config;
    int n;
    cfg_net_used = 4'b1011;
    cfg_init_en = 4'b0101;
    cfg_two_stage = 4'b0010;
    want_en = 4'b0101;
    step(3);
    cfg_done = 1'b1;
    n = 0;
    while (user_mode_q !== 1'b1 && n < 10)
    begin
      step(1);
      n++;
    end
    check("user mode", 8'h01, {7'h0, user_mode_q});
    check("init state", 8'h01, {4'h0, net_on_q});
    step(10);
    ticks(0, "net0 ticks", 10);
    ticks(2, "unused ticks", 0);
    ticks(3, "off ticks", 0);
  endtask : t_config
  // One- and two-register paths enabled together
  task automatic t_stages;
    int l1;
    int l3;
    l1 = 0;
    l3 = 0;
    want_en = 4'b1011;
    step(1);
    while (net_ena[3] !== 1'b1 && l1 < 5)
    begin
      step(1);
      l1++;
    end
    l1 = 0;
    repeat (8)
    begin
      step(1);
      l1 += (net_on_q[1] !== 1'b1);
      l3 += (net_on_q[3] !== 1'b1);
    end
    check("one-stage lag", 8'h01, 8'(l3));
    check("stage gap", 8'(l3 + 1), 8'(l1));
    ticks(3, "net3 ticks", 10);
    want_en = 4'b1010;
    step(8);
    ticks(0, "net0 off", 0);
  endtask : t_stages
  task automatic t_switch;
    want_sel[3] = 2'h1;
    step(20);
    ticks(3, "net3 on src1", 20);
    want_sel[3] = 2'h3;
    step(20);
    ticks(3, "net3 on src3", 0);
  endtask : t_switch
  // Losing configuration, enables refused, then reload with a new init state
  task automatic t_reload;
    int n;
    cfg_done = 1'b0;
    step(8);
    check("mode lost", 8'h00, {7'h0, user_mode_q});
    want_en = 4'b0000;
    step(8);
    check("held outside user", 8'h0a, {4'h0, net_on_q});
    cfg_init_en = 4'b1001;
    step(3);
    cfg_done = 1'b1;
    n = 0;
    while (user_mode_q !== 1'b1 && n < 10)
    begin
      step(1);
      n++;
    end
    check("reload init", 8'h09, {4'h0, net_on_q});
    step(4);
    check("enable after reload", 8'h00, {4'h0, net_on_q});
  endtask : t_reload
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  initial
  begin
    step(6);
    reset_n = 1'b1;
    t_config();
    t_stages();
    t_switch();
    t_reload();
    close_out();
  end
endmodule : glclk_top_tb_top
